// *** src/program_memory_map.svh ***
// program memory map constants: region bounds, reset values, bank and pin counts
// assumes inclusion by bare name from the design files
`ifndef PROGRAM_MEMORY_MAP_SVH
`define PROGRAM_MEMORY_MAP_SVH

`define PM_ADDR_W          16
`define PM_VECTOR_LO       16'h0000
`define PM_VECTOR_HI       16'h003F
`define PM_RESET_VEC_LO    16'h0000
`define PM_RESET_VEC_HI    16'h0001
`define PM_TABLE_CALL_INSTRUCTION_LO        16'h0040
`define PM_TABLE_CALL_INSTRUCTION_HI        16'h007F
`define PM_OPTION_NORMAL   16'h0080
`define PM_OPTION_SWAP     16'h1080
`define PM_SEC_FLAG_NORMAL 16'h0084
`define PM_SEC_FLAG_SWAP   16'h1084
`define PM_SEC_CODE_NORMAL 16'h0085
`define PM_SEC_CODE_SWAP   16'h1085
`define PM_SEC_CODE_LEN    4'hA
`define PM_DEBUG_LO        16'h008F
`define PM_DEBUG_HI        16'h018F
`define PM_SHORT_DIRECT_CALL_INSTRUCTION_LO        16'h0800
`define PM_SHORT_DIRECT_CALL_INSTRUCTION_HI        16'h0FFF
`define PM_COMMON_HI       16'h7FFF
`define PM_BANK_LO         16'h8000
`define PM_BANK_HI         16'hBFFF
`define PM_FLAT60_HI       16'hEFFF
`define PM_BANK_COUNT      3'h6
`define PM_IMS_RESET       8'hCF
`define PM_IXS_RESET       8'h0C
`define PM_IMS_BANKED      8'hCC
`define PM_IXS_BANKED      8'h00
`define PM_ANALOG_PINS     8

`endif

// *** src/program_memory_pkg.sv ***
// types for the program memory map decoder
// assumes the map header sits in the include path
package program_memory_pkg;
  // product variant of the flash array
  typedef enum logic [1:0] {
    VARIANT_FLAT32 = 2'h0,
    VARIANT_FLAT60 = 2'h1,
    VARIANT_BANKED = 2'h2
  } variant_e;

  // start-up sequence, gray coded along the path
  typedef enum logic [1:0] {
    BOOT_RD_LO  = 2'h0,
    BOOT_RD_HI  = 2'h1,
    BOOT_RUN    = 2'h3
  } boot_state_e;

  // region classification of a program address
  typedef enum logic [2:0] {
    REGION_VECTOR  = 3'h0,
    REGION_TABLE_CALL_INSTRUCTION   = 3'h1,
    REGION_OPTION  = 3'h2,
    REGION_SECURE  = 3'h3,
    REGION_DEBUG   = 3'h4,
    REGION_SHORT_DIRECT_CALL_INSTRUCTION   = 3'h5,
    REGION_PROGRAM = 3'h6,
    REGION_NONE    = 3'h7
  } region_e;
endpackage

// *** src/region_decoder.sv ***
// combinational classification of a program address into its region
// assumes debug and swap levels already synchronised by the caller
`timescale 1ns/1ps
`include "program_memory_map.svh"
module region_decoder
  import program_memory_pkg::*;
(
  // address and mode
  input  wire logic [15:0] i_addr,
  input  wire logic        i_swap,
  input  wire logic        i_debug_variant,
  // result
  output region_e          o_region
);
  logic [15:0] opt_a;  // option byte location
  logic [15:0] flag_a; // security flag location
  logic [15:0] code_a; // security code base

  // pick swapped or normal locations
  always_comb begin
    opt_a  = i_swap ? `PM_OPTION_SWAP : `PM_OPTION_NORMAL;
    flag_a = i_swap ? `PM_SEC_FLAG_SWAP : `PM_SEC_FLAG_NORMAL;
    code_a = i_swap ? `PM_SEC_CODE_SWAP : `PM_SEC_CODE_NORMAL;
  end

  // first match wins, special bytes before wide areas
  always_comb begin
    if (i_addr <= `PM_VECTOR_HI) begin
      o_region = REGION_VECTOR;
    end else if (i_addr >= `PM_TABLE_CALL_INSTRUCTION_LO && i_addr <= `PM_TABLE_CALL_INSTRUCTION_HI) begin
      o_region = REGION_TABLE_CALL_INSTRUCTION;
    end else if (i_addr == opt_a) begin
      o_region = REGION_OPTION;
    end else if (i_debug_variant && (i_addr == flag_a ||
               (i_addr >= code_a && i_addr < code_a + 16'({12'h000, `PM_SEC_CODE_LEN})))) begin
      o_region = REGION_SECURE;
    end else if (i_addr >= `PM_DEBUG_LO && i_addr <= `PM_DEBUG_HI) begin
      o_region = REGION_DEBUG;
    end else if (i_addr >= `PM_SHORT_DIRECT_CALL_INSTRUCTION_LO && i_addr <= `PM_SHORT_DIRECT_CALL_INSTRUCTION_HI) begin
      o_region = REGION_SHORT_DIRECT_CALL_INSTRUCTION;
    end else begin
      o_region = REGION_PROGRAM;
    end
  end
endmodule

// *** src/program_memory_map_decoder.sv ***
// program memory map decoder: variant decode, reset vector, option reads
// assumes a flash array with one-cycle registered read data
`timescale 1ns/1ps
`include "program_memory_map.svh"
module program_memory_map_decoder
  import program_memory_pkg::*;
#(
  parameter variant_e VARIANT        = VARIANT_BANKED,
  parameter logic     DEBUG_VARIANT  = 1'b1
)(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // core fetch path
  input  wire logic        i_fetch_req,
  input  wire logic [15:0] i_fetch_addr,
  input  wire logic        i_short_call,
  input  wire logic        i_pc_load,
  input  wire logic [15:0] i_pc_value,
  // setup software writes of the size selections
  input  wire logic        i_ims_we,
  input  wire logic        i_ixs_we,
  input  wire logic [7:0]  i_size_wdata,
  input  wire logic [2:0]  i_bank_sel,
  // pins from outside the clock domain
  input  wire logic        i_boot_swap,
  input  wire logic        i_debug_on,
  // flash array
  input  wire logic [7:0]  i_flash_rdata,
  output logic             o_flash_en,
  output logic [16:0]      o_flash_addr,
  // to the core
  output logic [15:0]      o_program_counter,
  output logic             o_core_run,
  output logic [7:0]       o_fetch_data,
  output logic             o_fetch_valid,
  output logic             o_fetch_fault,
  output logic [2:0]       o_fetch_region,
  // settings and pin modes
  output logic [7:0]       o_internal_memory_size_select,
  output logic [7:0]       o_expansion_ram_size_select,
  output logic [7:0]       o_option_byte,
  output logic [`PM_ANALOG_PINS-1:0] o_port2_analog_mode
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] swap_sync_q;   // boot swap strap, three stages
  logic [2:0] dbg_sync_q;    // debug enable, three stages
  logic       swap_q;        // accepted swap level
  logic       dbg_q;         // accepted debug level

  // shift pins in; only stages two and three are compared
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      swap_sync_q <= 3'h0;
      dbg_sync_q  <= 3'h0;
    end else begin
      swap_sync_q <= {swap_sync_q[1:0], i_boot_swap};
      dbg_sync_q  <= {dbg_sync_q[1:0], i_debug_on};
    end
  end

  // change counts once stages two and three agree
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      swap_q <= 1'b0;
      dbg_q  <= 1'b0;
    end else begin
      if (swap_sync_q[1] == swap_sync_q[2]) begin
        swap_q <= swap_sync_q[2];
      end
      if (dbg_sync_q[1] == dbg_sync_q[2]) begin
        dbg_q <= dbg_sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // size selections
  logic [7:0] ims_q; // internal memory size selection
  logic [7:0] ixs_q; // expansion ram size selection

  // fixed reset values whatever the variant; software rewrites them
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ims_q <= `PM_IMS_RESET;
      ixs_q <= `PM_IXS_RESET;
    end else begin
      if (i_ims_we) begin
        ims_q <= i_size_wdata;
      end
      if (i_ixs_we) begin
        ixs_q <= i_size_wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configured rom limit from the low nibble of the size selection
  logic [16:0] rom_limit; // first address past configured rom

  // low nibble picks the rom size; unknown codes give full space
  always_comb begin
    case (ims_q[3:0])
      4'h8:    rom_limit = 17'h08000;
      4'hC:    rom_limit = 17'h0C000;
      4'hF:    rom_limit = 17'h0F000;
      default: rom_limit = 17'h10000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // boot sequence and program counter
  boot_state_e boot_q;   // start-up state
  logic [15:0] pc_q;     // program counter
  logic [7:0]  vec_lo_q; // captured low vector byte
  logic [16:0] phys_d;   // physical flash address
  logic        in_rom_d; // address inside this variant's flash
  logic [15:0] fetch_a;  // address presented this cycle
  logic        fetch_go; // a flash read is asked for
  logic        core_go;    // a core request is taken this edge
  logic [1:0]  vec_a_q;    // vector read tag at the strobe: {high, low}
  logic [1:0]  vec_b_q;    // vector read tag while its data stands
  logic        vec_done_q; // reset vector loaded, core may start

  // the reset vector serves every cause since all share this reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      boot_q   <= BOOT_RD_LO;
      vec_lo_q <= 8'h00;
      pc_q     <= 16'h0000;
      vec_done_q <= 1'b0;
    end else begin
      case (boot_q)
        BOOT_RD_LO: begin
          boot_q <= BOOT_RD_HI;
        end
        BOOT_RD_HI: begin
          boot_q   <= BOOT_RUN;
        end
        BOOT_RUN: begin
          // vector bytes stand one edge after their strobe
          if (vec_b_q[0]) begin
            vec_lo_q <= i_flash_rdata;
          end
          if (vec_b_q[1]) begin
            pc_q       <= {i_flash_rdata, vec_lo_q};
            vec_done_q <= 1'b1;
          end else if (i_pc_load && o_core_run) begin
            pc_q <= i_pc_value;
          end
        end
        default: begin
          boot_q <= BOOT_RD_LO;
        end
      endcase
    end
  end

  // vector reads during boot, else the core's address once it runs
  always_comb begin
    case (boot_q)
      BOOT_RD_LO: fetch_a = `PM_RESET_VEC_LO;
      BOOT_RD_HI: fetch_a = `PM_RESET_VEC_HI;
      default:    fetch_a = i_fetch_addr;
    endcase
    core_go  = o_core_run && i_fetch_req;
    fetch_go = (boot_q != BOOT_RUN) || core_go;
  end

  ////////////////////////////////////////////////////////////////////
  // variant decode to physical flash address
  always_comb begin
    phys_d   = {1'b0, fetch_a};
    in_rom_d = 1'b1;
    case (VARIANT)
      VARIANT_FLAT32: begin
        in_rom_d = (fetch_a <= `PM_COMMON_HI);
      end
      VARIANT_FLAT60: begin
        in_rom_d = (fetch_a <= `PM_FLAT60_HI);
      end
      VARIANT_BANKED: begin
        if (fetch_a <= `PM_COMMON_HI) begin
          phys_d = {1'b0, fetch_a};
        end else if (fetch_a <= `PM_BANK_HI && i_bank_sel < `PM_BANK_COUNT) begin
          // bank n sits above the common area in the array
          phys_d = 17'h08000 + {i_bank_sel, fetch_a[13:0]};
        end else begin
          in_rom_d = 1'b0;
        end
      end
      default: begin
        in_rom_d = 1'b0;
      end
    endcase
    // limit set by software beats the physical size
    if ({1'b0, fetch_a} >= rom_limit) begin
      in_rom_d = 1'b0;
    end
  end

  // region of the requested address
  region_e region_raw; // decoder result
  region_e region_d;   // debug area released when not debugging
  region_decoder u_region (
    .i_addr          (fetch_a),
    .i_swap          (swap_q),
    .i_debug_variant (DEBUG_VARIANT),
    .o_region        (region_raw)
  );

  // the debugger's command area is only special while debugging runs
  assign region_d = (region_raw == REGION_DEBUG && !dbg_q) ? REGION_PROGRAM : region_raw;

  logic short_direct_call_instruction_bad; // short call aimed outside its entry area
  assign short_direct_call_instruction_bad = core_go && i_short_call && (region_d != REGION_SHORT_DIRECT_CALL_INSTRUCTION);

  ////////////////////////////////////////////////////////////////////
  // flash request and return
  logic        pend_q;   // core read launched, strobe stands
  logic        fault_q;  // request refused
  logic        opt_rd_q; // read was the option byte
  region_e     reg_q;    // region of the launched read
  logic        pend2_q;  // core read data stands this cycle
  logic        fault2_q; // refusal, lined up with the data stage
  logic        opt2_q;   // option byte data stands this cycle
  region_e     reg2_q;   // region, lined up with the data stage
  logic        rd_ok;    // the flash may be read this edge

  assign rd_ok = fetch_go && in_rom_d && !short_direct_call_instruction_bad;

  // launch reads; refused ones never touch the flash
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flash_en   <= 1'b0;
      o_flash_addr <= 17'h00000;
      pend_q       <= 1'b0;
      fault_q      <= 1'b0;
      opt_rd_q     <= 1'b0;
      reg_q        <= REGION_NONE;
      vec_a_q      <= 2'h0;
    end else begin
      o_flash_en   <= rd_ok;
      o_flash_addr <= phys_d;
      pend_q       <= rd_ok && core_go;
      fault_q      <= core_go && (!in_rom_d || short_direct_call_instruction_bad);
      opt_rd_q     <= rd_ok && core_go && (region_d == REGION_OPTION);
      reg_q        <= region_d;
      vec_a_q      <= {boot_q == BOOT_RD_HI, boot_q == BOOT_RD_LO};
    end
  end

  // the flash registers its byte one edge after the strobe, so every
  // tag waits one more cycle to meet the data it belongs to
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend2_q  <= 1'b0;
      fault2_q <= 1'b0;
      opt2_q   <= 1'b0;
      reg2_q   <= REGION_NONE;
      vec_b_q  <= 2'h0;
    end else begin
      pend2_q  <= pend_q;
      fault2_q <= fault_q;
      opt2_q   <= opt_rd_q;
      reg2_q   <= reg_q;
      vec_b_q  <= vec_a_q;
    end
  end

  // answers to the core, two edges after the taking edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fetch_data   <= 8'h00;
      o_fetch_valid  <= 1'b0;
      o_fetch_fault  <= 1'b0;
      o_fetch_region <= REGION_NONE;
      o_option_byte  <= 8'h00;
    end else begin
      o_fetch_valid  <= pend2_q;
      o_fetch_fault  <= fault2_q;
      o_fetch_data   <= pend2_q ? i_flash_rdata : 8'h00;
      o_fetch_region <= reg2_q;
      if (opt2_q) begin
        o_option_byte <= i_flash_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs from flip-flops
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_program_counter             <= 16'h0000;
      o_core_run                    <= 1'b0;
      o_internal_memory_size_select <= `PM_IMS_RESET;
      o_expansion_ram_size_select   <= `PM_IXS_RESET;
      o_port2_analog_mode           <= '1;
    end else begin
      o_program_counter             <= pc_q;
      o_core_run                    <= vec_done_q;
      o_internal_memory_size_select <= ims_q;
      o_expansion_ram_size_select   <= ixs_q;
      o_port2_analog_mode           <= o_port2_analog_mode;
    end
  end

endmodule

// *** dv/flash_model.sv ***
// flash array model for the decoder's far side
// assumes a one-cycle read strobe and a 17-bit physical byte address
`timescale 1ns/1ps
module flash_model (
  // clock
  input  wire logic        i_clk,
  // read port
  input  wire logic        i_en,
  input  wire logic [16:0] i_addr,
  output logic [7:0]       o_rdata
);
  ////////////////////////////////////////////////////////////////
  // byte folded by XOR from every address bit, so a one-bit address error shows as wrong data
  function automatic logic [7:0] pat(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {a[16], 7'h5A};
  endfunction
  initial o_rdata = 8'hA5;
  // data one cycle after the strobe; idle cycles invert, never stale
  always @(posedge i_clk) begin
    if (i_en) begin
      o_rdata <= pat(i_addr);
    end else begin
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// *** dv/program_memory_map_decoder_props.sv ***
// checker for the program memory map decoder's ports
// assumes a bind from the testbench top file
`timescale 1ns/1ps
module program_memory_map_decoder_props (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_resetn,
  // core side
  input wire logic        i_fetch_req,
  input wire logic [15:0] i_fetch_addr,
  input wire logic        i_short_call,
  input wire logic        i_pc_load,
  input wire logic [15:0] i_pc_value,
  input wire logic [2:0]  i_bank_sel,
  // outputs watched
  input wire logic        o_flash_en,
  input wire logic [16:0] o_flash_addr,
  input wire logic [15:0] o_program_counter,
  input wire logic        o_core_run,
  input wire logic        o_fetch_valid,
  input wire logic        o_fetch_fault,
  input wire logic [7:0]  o_internal_memory_size_select,
  input wire logic [7:0]  o_expansion_ram_size_select,
  input wire logic [7:0]  o_port2_analog_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////
  logic taken;    // request taken this edge
  logic bad_call; // short call outside its entry area
  logic ims_cc;   // banked setup in force
  assign taken    = o_core_run && i_fetch_req;
  assign bad_call = i_short_call && (i_fetch_addr < 16'h0800 || i_fetch_addr > 16'h0FFF);
  assign ims_cc   = o_internal_memory_size_select == 8'hCC;
  ////////////////////////////////////////////////////////////////
  a_reset_sizes: assert property (
    $rose(i_resetn) |-> o_internal_memory_size_select == 8'hCF
      && o_expansion_ram_size_select == 8'h0C) else $error("size selections off after reset");
  a_analog_reset: assert property (
    $rose(i_resetn) |-> o_port2_analog_mode == 8'hFF) else $error("pins not analog");
  a_boot_reads: assert property (
    $rose(i_resetn) |=> o_flash_en && o_flash_addr == 17'h00000 ##1 o_flash_addr == 17'h00001)
    else $error("vector bytes not read in order");
  a_run_in_time: assert property (
    $rose(i_resetn) |-> ##[4:6] $rose(o_core_run)) else $error("core not started in time");
  a_quiet_before: assert property (
    !o_core_run |-> !o_fetch_valid && !o_fetch_fault) else $error("answer before run");
  a_answer_time: assert property (
    taken |-> ##[2:3] (o_fetch_valid || o_fetch_fault)) else $error("fetch left unanswered");
  a_call_refused: assert property (
    taken && bad_call |=> !o_flash_en ##[1:2] o_fetch_fault) else $error("bad call not refused");
  a_common_addr: assert property (
    taken && !i_short_call && i_fetch_addr <= 16'h7FFF
      |=> o_flash_en && o_flash_addr == {1'b0, $past(i_fetch_addr)})
    else $error("common area address wrong");
  a_bank_window: assert property (
    taken && ims_cc && !i_short_call && i_fetch_addr[15:14] == 2'h2 && i_bank_sel < 3'h6
      |=> o_flash_en && o_flash_addr == 17'h08000 + {$past(i_bank_sel), 14'h0000}
        + {3'h0, $past(i_fetch_addr[13:0])}) else $error("bank address wrong");
  a_beyond_limit: assert property (
    taken && ims_cc && i_fetch_addr >= 16'hC000 |=> !o_flash_en ##[1:2] o_fetch_fault)
    else $error("fetch beyond limit not refused");
  a_pc_load: assert property (
    o_core_run && i_pc_load && !i_fetch_req |-> ##2 o_program_counter == $past(i_pc_value, 2))
    else $error("counter not loaded");
endmodule

// *** dv/testbench.sv ***
// self-checking bench for the banked decoder with a flash model
// assumes the checker is bound below and the flash model beside it
`timescale 1ns/1ps
module testbench
  import program_memory_pkg::*;
();
  logic        i_clk, i_resetn, i_fetch_req, i_short_call, i_pc_load;
  logic        i_ims_we, i_ixs_we, i_boot_swap, i_debug_on;
  logic [15:0] i_fetch_addr, i_pc_value;
  logic [7:0]  i_size_wdata, i_flash_rdata;
  logic [2:0]  i_bank_sel;
  logic        o_flash_en, o_core_run, o_fetch_valid, o_fetch_fault;
  logic [16:0] o_flash_addr;
  logic [15:0] o_program_counter;
  logic [7:0]  o_fetch_data, o_option_byte, o_port2_analog_mode;
  logic [7:0]  o_internal_memory_size_select, o_expansion_ram_size_select;
  logic [2:0]  o_fetch_region;
  int          n_errors = 0;
  int          n_compared = 0;
  ////////////////////////////////////////////////////////////////
  program_memory_map_decoder u_program_memory_map_decoder (.i_clk, .i_resetn, .i_fetch_req,
    .i_fetch_addr, .i_short_call, .i_pc_load, .i_pc_value, .i_ims_we, .i_ixs_we,
    .i_size_wdata, .i_bank_sel, .i_boot_swap, .i_debug_on, .i_flash_rdata, .o_flash_en,
    .o_flash_addr, .o_program_counter, .o_core_run, .o_fetch_data, .o_fetch_valid,
    .o_fetch_fault, .o_fetch_region, .o_internal_memory_size_select,
    .o_expansion_ram_size_select, .o_option_byte, .o_port2_analog_mode);
  flash_model u_flash_model (.i_clk, .i_en(o_flash_en), .i_addr(o_flash_addr),
    .o_rdata(i_flash_rdata));
  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // expected flash byte, worked out on its own
  function automatic logic [7:0] byte_at(input logic [16:0] a);
    return a[7:0] ^ a[15:8] ^ {a[16], 7'h5A};
  endfunction
  task automatic check(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d wrong %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // reset for 12 cycles, then wait for the core to start
  task automatic t_boot();
    i_resetn = 1'b0;
    repeat (12) @(negedge i_clk);
    check("strobe in reset", 0, o_flash_en);
    check("size in reset", 8'hCF, o_internal_memory_size_select);
    check("ram size in reset", 8'h0C, o_expansion_ram_size_select);
    check("analog in reset", 8'hFF, o_port2_analog_mode);
    i_resetn = 1'b1;
    for (int k = 0; k < 20 && o_core_run !== 1'b1; k++) @(negedge i_clk);
    check("run", 1, o_core_run);
    check("reset counter", 16'h5B5A, o_program_counter);
  endtask
  // one request; flash address seen a cycle on, answer bounded
  task automatic fetch(input logic [15:0] a, input logic sc, input logic [2:0] bk,
                       input logic flt, input logic [16:0] ph, input logic [2:0] rg);
    i_fetch_addr = a;
    i_short_call = sc;
    i_bank_sel   = bk;
    i_fetch_req  = 1'b1;
    @(negedge i_clk);
    i_fetch_req = 1'b0;
    check("strobe", !flt, o_flash_en);
    if (!flt) check("flash address", ph, o_flash_addr);
    for (int k = 0; k < 6 && o_fetch_valid !== 1'b1 && o_fetch_fault !== 1'b1; k++)
      @(negedge i_clk);
    check("fault", flt, o_fetch_fault);
    if (!flt) begin
      check("data", byte_at(ph), o_fetch_data);
      check("region", rg, o_fetch_region);
    end
    @(negedge i_clk);
  endtask
  // one pulse on a size selection write
  task automatic set_size(input logic internal_memory_size_select, input logic [7:0] v);
    i_size_wdata = v;
    i_ims_we     = internal_memory_size_select;
    i_ixs_we     = !internal_memory_size_select;
    @(negedge i_clk);
    i_ims_we = 1'b0;
    i_ixs_we = 1'b0;
    @(negedge i_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // fixed areas at their edges, short call limits, counter load
  task automatic t_regions();
    fetch(16'h008F, 0, 0, 0, 17'h0008F, REGION_PROGRAM);
    i_debug_on = 1'b1;
    fetch(16'h0000, 0, 0, 0, 17'h00000, REGION_VECTOR);
    fetch(16'h003F, 0, 0, 0, 17'h0003F, REGION_VECTOR);
    fetch(16'h0040, 0, 0, 0, 17'h00040, REGION_TABLE_CALL_INSTRUCTION);
    fetch(16'h007F, 0, 0, 0, 17'h0007F, REGION_TABLE_CALL_INSTRUCTION);
    fetch(16'h0080, 0, 0, 0, 17'h00080, REGION_OPTION);
    check("option byte", byte_at(17'h00080), o_option_byte);
    fetch(16'h0084, 0, 0, 0, 17'h00084, REGION_SECURE);
    fetch(16'h008E, 0, 0, 0, 17'h0008E, REGION_SECURE);
    fetch(16'h008F, 0, 0, 0, 17'h0008F, REGION_DEBUG);
    fetch(16'h018F, 0, 0, 0, 17'h0018F, REGION_DEBUG);
    fetch(16'h0800, 1, 0, 0, 17'h00800, REGION_SHORT_DIRECT_CALL_INSTRUCTION);
    fetch(16'h0FFF, 1, 0, 0, 17'h00FFF, REGION_SHORT_DIRECT_CALL_INSTRUCTION);
    fetch(16'h07FF, 1, 0, 1, 17'h0, REGION_NONE);
    fetch(16'h1000, 1, 0, 1, 17'h0, REGION_NONE);
    fetch(16'h7FFF, 0, 0, 0, 17'h07FFF, REGION_PROGRAM);
    i_pc_value = 16'h1234;
    i_pc_load  = 1'b1;
    @(negedge i_clk);
    i_pc_load = 1'b0;
    @(negedge i_clk);
    check("loaded counter", 16'h1234, o_program_counter);
  endtask
  // size settings, banks and the configured limit
  task automatic t_sizes();
    set_size(1, 8'hC8);
    fetch(16'h8000, 0, 0, 1, 17'h0, REGION_NONE);
    set_size(1, 8'hCC);
    set_size(0, 8'h00);
    check("size", 8'hCC, o_internal_memory_size_select);
    check("ram size", 8'h00, o_expansion_ram_size_select);
    fetch(16'h8000, 0, 0, 0, 17'h08000, REGION_PROGRAM);
    fetch(16'hBFFF, 0, 5, 0, 17'h1FFFF, REGION_PROGRAM);
    fetch(16'h8000, 0, 6, 1, 17'h0, REGION_NONE);
    fetch(16'hC000, 0, 0, 1, 17'h0, REGION_NONE);
  endtask
  // boot swap: second reset in mid-run, option byte moves up
  task automatic t_swap();
    i_boot_swap = 1'b1;
    t_boot();
    fetch(16'h1080, 0, 0, 0, 17'h01080, REGION_OPTION);
    check("swapped option", byte_at(17'h01080), o_option_byte);
    fetch(16'h1084, 0, 0, 0, 17'h01084, REGION_SECURE);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {i_resetn, i_fetch_req, i_short_call, i_pc_load, i_ims_we, i_ixs_we} = 6'h00;
    {i_boot_swap, i_debug_on, i_bank_sel} = 5'h00;
    {i_fetch_addr, i_pc_value, i_size_wdata} = 40'h0;
    t_boot();
    t_regions();
    t_sizes();
    t_swap();
    tally_and_finish();
  end
  // a hang ends the run as a failure
  initial begin
    #100us;
    n_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
endmodule

bind program_memory_map_decoder program_memory_map_decoder_props u_props (.i_clk, .i_resetn,
  .i_fetch_req, .i_fetch_addr, .i_short_call, .i_pc_load, .i_pc_value, .i_bank_sel,
  .o_flash_en, .o_flash_addr, .o_program_counter, .o_core_run, .o_fetch_valid,
  .o_fetch_fault, .o_internal_memory_size_select, .o_expansion_ram_size_select,
  .o_port2_analog_mode);
